// >>> rtl/spibf_pkg.sv
// Operation
// - Serial side always wins buffer arbitration
// - Serial access blocks CPU two bit periods
// - Stall option holds CPU with waits
// - No stall: failed read all ones, write dropped
// - Good buffer read is zero-extended byte
// - Conflicting write/read sets tx/rx flag
// - Flags readable, masked onto interrupt
// - Master internal FIFO; slave adds modes
// - External slave FIFO: wake, drop, send FF
// - Master clock only when sending, unless free
// - Bit spans oversample factor plus one
// - Late sample uses next edge, resets zero
// - Slave ignores oversample and late sample
// - Buffered/command modes only as slave
// - Settings but stall apply only at next enable
// - Enabling reinitializes internal state
// - Buffer reached by words, low byte used
// - Serial buffer address stops at last
package spibf_pkg;
	localparam int          BUF_AW_DEF     = 8;
	localparam logic [11:0] OFF_CTRL       = 12'h000;
	localparam logic [11:0] OFF_SPI        = 12'h004;
	localparam logic [11:0] OFF_STAT       = 12'h008;
	localparam logic [11:0] OFF_MASK       = 12'h00C;
	localparam logic [11:0] OFF_TXD        = 12'h010;
	localparam logic [11:0] OFF_RXD        = 12'h014;
	localparam logic [11:0] OFF_BASE       = 12'h018;
	localparam logic [11:0] OFF_CUR        = 12'h01C;
	localparam logic [1:0]  BUF_WIN        = 2'h1;
	localparam int          CTRL_OVS_LSB   = 0;
	localparam int          CTRL_STALL_BIT = 8;
	localparam int          CTRL_EXT_BIT   = 16;
	localparam int          CTRL_MODE_LSB  = 24;
	localparam int          CTRL_EN_BIT    = 31;
	localparam int          SPI_MASTER_BIT = 0;
	localparam int          SPI_FREE_BIT   = 5;
	localparam int          SPI_LATE_BIT   = 6;
	localparam int          ST_TXC_BIT     = 0;
	localparam int          ST_RXC_BIT     = 1;
	localparam int          ST_WAKE_BIT    = 2;
	localparam int          ST_RXV_BIT     = 3;
	localparam int          ST_TXF_BIT     = 4;
	localparam int          ST_BUSY_BIT    = 5;
	localparam int          BASE_RD_LSB    = 8;
	localparam logic [3:0]  OVS_RST        = 4'h7;
	localparam logic        LATE_RST       = 1'b0;
	localparam logic [31:0] FAIL_WORD      = 32'hFFFFFFFF;
	localparam logic [7:0]  IDLE_BYTE      = 8'hFF;
	localparam logic [1:0]  EXT_HOLD_BITS  = 2'h2;
	localparam logic [2:0]  LAST_BIT       = 3'h7;
	typedef enum logic [1:0] {MODE_FIFO, MODE_BUF, MODE_CMD} spibf_mode_type;
	typedef enum logic {MST_IDLE, MST_XFER} spibf_mst_type;
endpackage

// >>> rtl/spibf_mem.sv
`timescale 1ns/1ps
`default_nettype none
module spibf_mem #(
	parameter int AW = 8,
	parameter int DW = 8
) (
	// Clock
	input  wire logic          clk_i,
	// Single port
	input  wire logic          we_i,
	input  wire logic [AW-1:0] addr_i,
	input  wire logic [DW-1:0] wdata_i,
	output logic      [DW-1:0] rdata_o
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	if (AW < 1 || AW > 8 || DW < 1) begin : g_bad
		$error("spibf_mem: unsupported size");
	end

	// Read data registered; no reset so it maps onto block memory
	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem[addr_i] <= wdata_i;
		end
		rdata_o <= mem[addr_i];
	end
endmodule
`default_nettype wire

// >>> rtl/spibf_top.sv
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module spibf_top #(
	parameter int BUF_AW = spibf_pkg::BUF_AW_DEF
) (
	// Clock and reset
	input  wire logic        CLK_I,
	input  wire logic        RST_I,
	// APB slave
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic        PWRITE_I,
	input  wire logic [11:0] PADDR_I,
	input  wire logic [31:0] PWDATA_I,
	output logic      [31:0] PRDATA_O,
	output logic             PREADY_O,
	output logic             PSLVERR_O,
	// Serial pins
	input  wire logic        SCLK_I,
	output logic             SCLK_O,
	output logic             SCLK_OE_O,
	input  wire logic        SS_N_I,
	output logic             SS_N_O,
	output logic             SS_N_OE_O,
	input  wire logic        MOSI_I,
	output logic             MOSI_O,
	output logic             MOSI_OE_O,
	input  wire logic        MISO_I,
	output logic             MISO_O,
	output logic             MISO_OE_O,
	// Interrupt
	output logic             IRQ_O
);
	import spibf_pkg::*;

	if (BUF_AW < 1 || BUF_AW > 8) begin : g_bad
		$error("spibf_top: BUF_AW must be 1..8");
	end

	////////////////////////////////////////////////////////////////////////
	logic                en, next_en, stall, next_stall, ext, next_ext;
	logic                master, next_master, free_clk, next_free_clk;
	logic                late, next_late;
	logic [3:0]          oversample_factor, next_ovs, c_ovs, next_c_ovs, cnt, next_cnt;
	logic [1:0]          mode, next_mode, ext_left, next_ext_left;
	logic                c_master, next_c_master, c_free, next_c_free;
	logic                c_late, next_c_late, c_ext, next_c_ext;
	spibf_mode_type      c_mode, next_c_mode;
	spibf_mst_type       mstate, next_mstate;
	logic                flag_tx, next_flag_tx, flag_rx, next_flag_rx;
	logic                flag_wake, next_flag_wake;
	logic [2:0]          mask, next_mask, bitcnt, next_bitcnt;
	logic [BUF_AW-1:0]   base_wr, next_base_wr, base_rd, next_base_rd;
	logic [BUF_AW-1:0]   cur_wr, next_cur_wr, cur_rd, next_cur_rd;
	logic [7:0]          tx_data, next_tx_data, rx_data, next_rx_data;
	logic [7:0]          sh_out, next_sh_out, sh_in, next_sh_in;
	logic [7:0]          tx_next, next_tx_next;
	logic                tx_full, next_tx_full, rx_valid, next_rx_valid;
	logic                sclk_o, next_sclk_o, ss_o, next_ss_o;
	logic                mosi_o, next_mosi_o, miso_o, next_miso_o;
	logic                mst_oe, next_mst_oe, miso_oe, next_miso_oe;
	logic                drop, next_drop, first, next_first;
	logic                sel_q, next_sel_q, rd_after, next_rd_after;
	logic                ext_cap, next_ext_cap, cpu_pend, next_cpu_pend;
	logic                cpu_flagged, next_cpu_flagged;
	logic                pready, next_pready, pslverr, next_pslverr;
	logic                irq, next_irq;
	logic [31:0]         prdata, next_prdata;
	logic [3:0]          meta, sync;
	logic                sclk_q;
	logic                m_we, ext_req, cpu_grant, conflict, en_rise;
	logic                acc, buf_acc, sclk_rise, sclk_fall, sel, rise, fall;
	logic [BUF_AW-1:0]   m_addr;
	logic [7:0]          m_wdata, m_rdata, byte_in, half;
	logic [31:0]         rd_val;

	function automatic logic is_buf(input logic [11:0] a);
		return a[11:10] == BUF_WIN;
	endfunction

	function automatic logic [BUF_AW-1:0] sat_inc(input logic [BUF_AW-1:0] a);
		return (&a) ? a : a + 1'b1;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Pins pass two flops; only the second stage and later are read
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			meta   <= 4'hF;
			sync   <= 4'hF;
			sclk_q <= 1'b1;
		end else begin
			meta   <= {MISO_I, MOSI_I, SS_N_I, SCLK_I};
			sync   <= meta;
			sclk_q <= sync[0];
		end
	end

	assign sclk_rise = sync[0] & ~sclk_q;
	assign sclk_fall = ~sync[0] & sclk_q;
	assign sel       = ~sync[1];
	assign byte_in   = {sh_in[6:0], c_master ? sync[3] : sync[2]};
	assign half      = 8'((9'(c_ovs) + 9'h1) >> 1);

	spibf_mem #(
		.AW (BUF_AW),
		.DW (8)
	) u_mem (
		.clk_i   (CLK_I),
		.we_i    (m_we),
		.addr_i  (m_addr),
		.wdata_i (m_wdata),
		.rdata_o (m_rdata)
	);

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		{next_en, next_stall, next_ext, next_master} = {en, stall, ext, master};
		{next_free_clk, next_late, next_ovs, next_mode} = {free_clk, late, oversample_factor, mode};
		{next_c_master, next_c_free, next_c_late} = {c_master, c_free, c_late};
		{next_c_ext, next_c_ovs} = {c_ext, c_ovs};
		next_c_mode = c_mode;
		{next_flag_tx, next_flag_rx, next_flag_wake, next_mask} =
			{flag_tx, flag_rx, flag_wake, mask};
		{next_base_wr, next_base_rd, next_cur_wr, next_cur_rd} =
			{base_wr, base_rd, cur_wr, cur_rd};
		{next_tx_data, next_rx_data, next_tx_full, next_rx_valid} =
			{tx_data, rx_data, tx_full, rx_valid};
		{next_sh_out, next_sh_in, next_tx_next, next_bitcnt, next_cnt} =
			{sh_out, sh_in, tx_next, bitcnt, cnt};
		{next_sclk_o, next_ss_o, next_mosi_o, next_miso_o} = {sclk_o, ss_o, mosi_o, miso_o};
		{next_drop, next_first, next_rd_after} = {drop, first, 1'b0};
		next_mstate = mstate;
		next_ext_left    = ext_left;
		next_cpu_flagged = cpu_flagged;
		next_sel_q       = sel;
		next_ext_cap     = 1'b0;
		next_cpu_pend    = 1'b0;
		next_pready      = 1'b0;
		next_pslverr     = 1'b0;
		next_prdata      = prdata;
		next_mst_oe      = en & c_master;
		next_miso_oe     = en & ~c_master & sel;
		m_we      = 1'b0;
		m_addr    = cur_wr;
		m_wdata   = byte_in;
		ext_req   = 1'b0;
		cpu_grant = 1'b0;
		en_rise   = 1'b0;
		rd_val    = 32'h00000000;
		rise      = 1'b0;
		fall      = 1'b0;
		acc       = PSEL_I & PENABLE_I & ~pready & ~cpu_pend;
		buf_acc   = acc & is_buf(PADDR_I);

		// Register access: one wait state, writes land before PREADY is sampled
		if (acc && !buf_acc) begin
			next_pready = 1'b1;
			case (PADDR_I)
				OFF_CTRL: begin
					rd_val[CTRL_OVS_LSB +: 4]  = oversample_factor;
					rd_val[CTRL_STALL_BIT]     = stall;
					rd_val[CTRL_EXT_BIT]       = ext;
					rd_val[CTRL_MODE_LSB +: 2] = mode;
					rd_val[CTRL_EN_BIT]        = en;
					if (PWRITE_I) begin
						next_ovs   = PWDATA_I[CTRL_OVS_LSB +: 4];
						next_stall = PWDATA_I[CTRL_STALL_BIT];
						next_ext   = PWDATA_I[CTRL_EXT_BIT];
						next_mode  = PWDATA_I[CTRL_MODE_LSB +: 2];
						next_en    = PWDATA_I[CTRL_EN_BIT];
						en_rise    = PWDATA_I[CTRL_EN_BIT] & ~en;
					end
				end
				OFF_SPI: begin
					rd_val[SPI_MASTER_BIT] = master;
					rd_val[SPI_FREE_BIT]   = free_clk;
					rd_val[SPI_LATE_BIT]   = late;
					if (PWRITE_I) begin
						next_master   = PWDATA_I[SPI_MASTER_BIT];
						next_free_clk = PWDATA_I[SPI_FREE_BIT];
						next_late     = PWDATA_I[SPI_LATE_BIT];
					end
				end
				OFF_STAT: begin
					rd_val[ST_TXC_BIT]  = flag_tx;
					rd_val[ST_RXC_BIT]  = flag_rx;
					rd_val[ST_WAKE_BIT] = flag_wake;
					rd_val[ST_RXV_BIT]  = rx_valid;
					rd_val[ST_TXF_BIT]  = tx_full;
					rd_val[ST_BUSY_BIT] = ext_left != 2'h0;
					if (PWRITE_I) begin
						next_flag_tx   = flag_tx & ~PWDATA_I[ST_TXC_BIT];
						next_flag_rx   = flag_rx & ~PWDATA_I[ST_RXC_BIT];
						next_flag_wake = flag_wake & ~PWDATA_I[ST_WAKE_BIT];
					end
				end
				OFF_MASK: begin
					rd_val[2:0] = mask;
					if (PWRITE_I) begin
						next_mask = PWDATA_I[2:0];
					end
				end
				OFF_TXD: begin
					rd_val[7:0] = tx_data;
					if (PWRITE_I) begin
						next_tx_data = PWDATA_I[7:0];
						next_tx_full = 1'b1;
					end
				end
				OFF_RXD: begin
					rd_val[7:0] = rx_data;
					if (!PWRITE_I) begin
						next_rx_valid = 1'b0;
					end
				end
				OFF_BASE: begin
					rd_val[BUF_AW-1:0]              = base_wr;
					rd_val[BASE_RD_LSB +: BUF_AW]   = base_rd;
					if (PWRITE_I) begin
						next_base_wr = PWDATA_I[BUF_AW-1:0];
						next_base_rd = PWDATA_I[BASE_RD_LSB +: BUF_AW];
					end
				end
				OFF_CUR: begin
					rd_val[BUF_AW-1:0]            = cur_wr;
					rd_val[BASE_RD_LSB +: BUF_AW] = cur_rd;
				end
				default: next_pslverr = 1'b1;
			endcase
			next_prdata = PWRITE_I ? prdata : rd_val;
		end

		// Settings but stall are latched only here, so edits to them while enabled stay inert
		if (en_rise) begin
			next_c_master = master;
			next_c_free   = free_clk;
			next_c_late   = late & master;
			next_c_ovs    = next_ovs;
			next_c_ext    = next_ext & ~master;
			next_c_mode   = MODE_FIFO;
			if (!master && next_mode == 2'h1) begin
				next_c_mode = MODE_BUF;
			end else if (!master && next_mode == 2'h2 && next_ext) begin
				next_c_mode = MODE_CMD;
			end
			{next_tx_full, next_rx_valid} = 2'h0;
			next_mstate = MST_IDLE;
			{next_bitcnt, next_cnt, next_ext_left} = {3'h0, 4'h0, 2'h0};
			// Select stays released until a transfer starts
			{next_sclk_o, next_ss_o, next_drop, next_cpu_flagged} = 4'h4;
		end else if (en && c_master) begin
			// Clock runs only in a transfer unless free running is on
			if (mstate == MST_XFER || c_free) begin
				if (cnt == c_ovs) begin
					next_cnt    = 4'h0;
					next_sclk_o = 1'b0;
					fall        = 1'b1;
				end else begin
					next_cnt = cnt + 4'h1;
					if (8'(cnt + 4'h1) == half) begin
						next_sclk_o = 1'b1;
						rise        = 1'b1;
					end
				end
			end
			// MISO is seen two cycles late through its synchroniser
			if (mstate == MST_XFER) begin
				if ((rise && !c_late) || (fall && c_late)) begin
					next_sh_in = byte_in;
				end
				if (fall) begin
					if (bitcnt == LAST_BIT) begin
						next_rx_data  = c_late ? byte_in : sh_in;
						next_rx_valid = 1'b1;
						next_ss_o     = 1'b1;
						next_mstate   = MST_IDLE;
					end else begin
						next_sh_out = {sh_out[6:0], 1'b0};
						next_mosi_o = sh_out[6];
					end
					next_bitcnt = bitcnt + 3'h1;
				end
			end else if (tx_full) begin
				{next_sh_out, next_mosi_o} = {tx_data, tx_data[7]};
				{next_tx_full, next_ss_o, next_bitcnt} = 5'h00;
				next_mstate = MST_XFER;
				{next_cnt, next_sclk_o} = {4'h0, 1'b0};
			end
		end else if (en) begin
			if (sel && !sel_q) begin
				{next_bitcnt, next_cur_wr, next_cur_rd} = {3'h0, base_wr, base_rd};
				if (c_ext) begin
					next_flag_wake = 1'b1;
				end
				if (c_mode == MODE_FIFO) begin
					next_drop = c_ext & ~tx_full;
					next_sh_out = (c_ext && !tx_full) ? IDLE_BYTE : tx_data;
					next_miso_o = (c_ext && !tx_full) ? IDLE_BYTE[7] : tx_data[7];
					next_tx_full = tx_full & c_ext & ~tx_full;
				end else begin
					{ext_req, m_addr, next_ext_cap, next_first} = {1'b1, base_rd, 2'h3};
				end
			end
			if (rd_after) begin
				{ext_req, m_addr, next_ext_cap} = {1'b1, cur_rd, 1'b1};
			end
			if (ext_cap) begin
				next_tx_next = m_rdata;
				if (first) begin
					{next_sh_out, next_miso_o, next_first} = {m_rdata, m_rdata[7], 1'b0};
				end
			end
			if (sel && sclk_rise) begin
				next_sh_in  = byte_in;
				next_bitcnt = bitcnt + 3'h1;
				if (ext_left != 2'h0) begin
					next_ext_left = ext_left - 2'h1;
				end
				if (bitcnt == LAST_BIT && c_mode == MODE_FIFO) begin
					if (!drop) begin
						{next_rx_data, next_rx_valid} = {byte_in, 1'b1};
					end
					next_drop    = drop & ~tx_full;
					next_tx_next = tx_full ? tx_data : IDLE_BYTE;
					next_tx_full = 1'b0;
				end else if (bitcnt == LAST_BIT) begin
					{ext_req, m_we, m_addr} = {2'h3, cur_wr};
					next_cur_wr   = sat_inc(cur_wr);
					next_cur_rd   = sat_inc(cur_rd);
					next_rd_after = 1'b1;
				end
			end
			if (sel && sclk_fall) begin
				next_sh_out = (bitcnt == 3'h0) ? tx_next : {sh_out[6:0], 1'b0};
				next_miso_o = (bitcnt == 3'h0) ? tx_next[7] : sh_out[6];
			end
			if (!sel) begin
				next_ext_left = 2'h0;
			end
		end
		if (ext_req) begin
			next_ext_left = EXT_HOLD_BITS;
		end

		// Buffer arbitration: the serial side always owns the port first
		conflict = ext_req | (ext_left != 2'h0);
		if (cpu_pend) begin
			next_prdata = {24'h000000, m_rdata};
			next_pready = 1'b1;
		end else if (buf_acc && conflict) begin
			if (!cpu_flagged) begin
				next_flag_tx = next_flag_tx | PWRITE_I;
				next_flag_rx = next_flag_rx | ~PWRITE_I;
			end
			next_cpu_flagged = stall;
			if (!stall) begin
				next_pready = 1'b1;
				next_prdata = PWRITE_I ? prdata : FAIL_WORD;
			end
		end else if (buf_acc) begin
			cpu_grant        = 1'b1;
			next_cpu_flagged = 1'b0;
			m_addr           = PADDR_I[BUF_AW+1:2];
			m_wdata          = PWDATA_I[7:0];
			m_we             = PWRITE_I;
			next_pready      = PWRITE_I;
			next_cpu_pend    = ~PWRITE_I;
		end
		next_irq = |({next_flag_wake, next_flag_rx, next_flag_tx} & mask);
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			{en, stall, ext, master, free_clk} <= 5'h00;
			late <= LATE_RST;
			{oversample_factor, c_ovs, mode} <= {OVS_RST, OVS_RST, 2'h0};
			{c_master, c_free, c_late, c_ext} <= 4'h0;
			c_mode <= MODE_FIFO;
			{flag_tx, flag_rx, flag_wake, mask} <= 6'h00;
			{base_wr, base_rd, cur_wr, cur_rd} <= '0;
			{tx_data, rx_data, tx_full, rx_valid} <= 18'h00000;
			{sh_out, sh_in, tx_next} <= {8'h00, 8'h00, IDLE_BYTE};
			{bitcnt, cnt, ext_left} <= 9'h000;
			mstate <= MST_IDLE;
			{sclk_o, ss_o, mosi_o, miso_o, mst_oe, miso_oe} <= 6'h14;
			{drop, first, sel_q, rd_after, ext_cap, cpu_pend} <= 6'h00;
			{cpu_flagged, pready, pslverr, irq, prdata} <= 36'h000000000;
		end else begin
			{en, stall, ext, master, free_clk} <=
				{next_en, next_stall, next_ext, next_master, next_free_clk};
			{late, oversample_factor, c_ovs, mode} <= {next_late, next_ovs, next_c_ovs, next_mode};
			{c_master, c_free, c_late, c_ext} <=
				{next_c_master, next_c_free, next_c_late, next_c_ext};
			c_mode <= next_c_mode;
			{flag_tx, flag_rx, flag_wake, mask} <=
				{next_flag_tx, next_flag_rx, next_flag_wake, next_mask};
			{base_wr, base_rd, cur_wr, cur_rd} <=
				{next_base_wr, next_base_rd, next_cur_wr, next_cur_rd};
			{tx_data, rx_data, tx_full, rx_valid} <=
				{next_tx_data, next_rx_data, next_tx_full, next_rx_valid};
			{sh_out, sh_in, tx_next} <= {next_sh_out, next_sh_in, next_tx_next};
			{bitcnt, cnt, ext_left} <= {next_bitcnt, next_cnt, next_ext_left};
			mstate <= next_mstate;
			{sclk_o, ss_o, mosi_o, miso_o, mst_oe, miso_oe} <=
				{next_sclk_o, next_ss_o, next_mosi_o, next_miso_o, next_mst_oe, next_miso_oe};
			{drop, first, sel_q, rd_after, ext_cap, cpu_pend} <=
				{next_drop, next_first, next_sel_q, next_rd_after, next_ext_cap, next_cpu_pend};
			{cpu_flagged, pready, pslverr, irq, prdata} <=
				{next_cpu_flagged, next_pready, next_pslverr, next_irq, next_prdata};
		end
	end

	assign {SCLK_O, SCLK_OE_O, SS_N_O, SS_N_OE_O} = {sclk_o, mst_oe, ss_o, mst_oe};
	assign {MOSI_O, MOSI_OE_O, MISO_O, MISO_OE_O} = {mosi_o, mst_oe, miso_o, miso_oe};
	assign {PRDATA_O, PREADY_O, PSLVERR_O, IRQ_O} = {prdata, pready, pslverr, irq};

	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge CLK_I); endclocking
	default disable iff (RST_I);

	chk_serial_wins_port: assert property (ext_req |-> !cpu_grant)
		else $error("cpu granted while serial side requests");
	chk_hold_two_bits: assert property (ext_req |=> ext_left == 2'h2 && !cpu_grant)
		else $error("serial hold window not two bits");
	chk_stall_waits: assert property (buf_acc && conflict && stall |=> !pready)
		else $error("stalled access answered early");
	chk_fail_read_ones: assert property (
		buf_acc && conflict && !stall && !PWRITE_I |=> pready && prdata == FAIL_WORD)
		else $error("failed read not all ones");
	chk_fail_write_drop: assert property (buf_acc && conflict |-> !cpu_grant)
		else $error("conflicting write reached buffer");
	chk_read_zero_ext: assert property (cpu_pend |=> pready && prdata[31:8] == 24'h000000)
		else $error("buffer read not zero-extended");
	chk_conflict_flags: assert property (
		buf_acc && conflict && !cpu_flagged |=> (PWRITE_I ? flag_tx : flag_rx))
		else $error("conflict flag not set");
	chk_irq_masked: assert property (flag_rx && mask[1] && !$past(RST_I) |=> IRQ_O || !flag_rx)
		else $error("masked flag did not raise interrupt");
	chk_clock_quiet: assert property (
		en && c_master && !c_free && mstate == MST_IDLE && $past(mstate) == MST_IDLE |-> !sclk_o)
		else $error("master clock toggles while idle");
	chk_enable_reinit: assert property (en_rise |=> !tx_full && !rx_valid && mstate == MST_IDLE)
		else $error("enable did not reinitialise");
	chk_addr_saturate: assert property (m_we && ext_req && &cur_wr |=> &cur_wr)
		else $error("serial write address wrapped");

	cov_stall_wait: cover property (buf_acc && conflict && stall ##1 !pready ##[1:200] pready);
	cov_fail_read: cover property (buf_acc && conflict && !stall && !PWRITE_I);
	cov_master_byte: cover property (mstate == MST_XFER ##[1:300] mstate == MST_IDLE);
endmodule
`default_nettype wire

// >>> testbench/spibf_peer.sv
`timescale 1ns/1ps
`default_nettype none
module spibf_peer (
	// Clock and frame trigger
	input  wire logic       clk_i,
	input  wire logic       go_i,
	input  wire logic [7:0] mbyte_i,
	input  wire logic [7:0] sbyte_i,
	// Device acting as master
	input  wire logic       sclk_m_i,
	input  wire logic       ss_m_n_i,
	// Peer pins
	output logic            sclk_o,
	output logic            ss_n_o,
	output logic            mosi_o,
	output logic            miso_o,
	output logic            busy_o
);
	logic [7:0] sh;
	logic       tog;
	initial begin
		{sclk_o, ss_n_o, mosi_o, busy_o, tog, sh} = {4'h4, 1'b0, 8'h00};
	end
	////////////////////////////////////////////////////////////////////////////////
	// Mode 0 frame, clock still between frames; phase unrelated to CLK_I
	always @(posedge go_i) begin
		busy_o = 1'b1;
		#7 ss_n_o = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			mosi_o = mbyte_i[i];
			#40 sclk_o = 1'b1;
			#40 sclk_o = 1'b0;
		end
		#40 ss_n_o = 1'b1;
		mosi_o = ~mosi_o;
		busy_o = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// Slave side; unselected line keeps changing so no stale bit is read
	always @(negedge ss_m_n_i) sh = sbyte_i;
	always @(negedge sclk_m_i) if (!ss_m_n_i) sh = {sh[6:0], 1'b0};
	always @(posedge clk_i) tog <= ~tog;
	assign miso_o = ss_m_n_i ? tog : sh[7];
endmodule
`default_nettype wire

// >>> testbench/spibf_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module spibf_top_test;
	import spibf_pkg::*;
	logic        clk, rst, psel, pen, pwr, go, pready, err, irq, busy, rerr;
	logic [11:0] paddr;
	logic [31:0] pwd, prdata, rd;
	logic        sclk_o, ss_o, p_sclk, p_ss, p_mosi, p_miso;
	logic [7:0]  b [16];
	logic [7:0]  mb, sb;
	integer      seed = 63026;
	int          errors = 0;
	int          checks = 0;
	int          n, fails;
	spibf_top dut_u (.CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
		.PADDR_I(paddr), .PWDATA_I(pwd), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(err),
		.SCLK_I(p_sclk), .SCLK_O(sclk_o), .SCLK_OE_O(), .SS_N_I(p_ss), .SS_N_O(ss_o),
		.SS_N_OE_O(), .MOSI_I(p_mosi), .MOSI_O(), .MOSI_OE_O(), .MISO_I(p_miso), .MISO_O(),
		.MISO_OE_O(), .IRQ_O(irq));
	spibf_peer peer_u (.clk_i(clk), .go_i(go), .mbyte_i(mb), .sbyte_i(sb), .sclk_m_i(sclk_o),
		.ss_m_n_i(ss_o), .sclk_o(p_sclk), .ss_n_o(p_ss), .mosi_o(p_mosi), .miso_o(p_miso),
		.busy_o(busy));
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic summarize();
		$display("checks=%0d errors=%0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Request stands until the edge that samples ready high; the reply is taken there
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk);
		{psel, pen, pwr, paddr, pwd} <= {1'b1, 1'b0, w, a, d};
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 300);
		if (k >= 300) errors++;
		{rd, rerr} = {prdata, err};
		{psel, pen} <= 2'h0;
	endtask
	function automatic logic [11:0] bufa(input logic [7:0] i);
		return {BUF_WIN, i, 2'h0};
	endfunction
	// CPU hits one buffer word all through a serial frame
	task automatic hammer(input logic stall);
		fails = 0;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		while (busy === 1'b1) begin
			apb(1'b1, bufa(8'h03), {24'h0, b[3]});
			apb(1'b0, bufa(8'h03), 32'h0);
			if (rd === FAIL_WORD) fails++;
			else chk(rd, {24'h0, b[3]});
		end
		if (stall) chk(fails, 0);
		else chk(32'(fails != 0), 1);
		$display("conflict test done stall=%0d", stall);
	endtask
	task automatic frame();
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		wait (busy === 1'b0);
		@(posedge clk);
	endtask
	task automatic clk_gap();
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (sclk_o !== 1'b1 && n < 200);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (sclk_o === 1'b1 && n < 200);
		do begin
			@(negedge clk);
			n++;
		end while (sclk_o !== 1'b1 && n < 200);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{rst, psel, pen, pwr, go, paddr, pwd} = {5'h10, 44'h0};
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		apb(1'b0, OFF_CTRL, 32'h0);
		chk(rd[3:0], OVS_RST);
		apb(1'b0, OFF_SPI, 32'h0);
		chk(rd[SPI_LATE_BIT], LATE_RST);
		apb(1'b0, 12'h3F0, 32'h0);
		chk(rerr, 1'b1);
		$display("reset test done");
		apb(1'b1, OFF_SPI, 32'h0);
		apb(1'b1, OFF_BASE, 32'h4080);
		apb(1'b1, OFF_CTRL, 32'h81000007);
		for (int i = 0; i < 16; i++) begin
			b[i] = 8'($random(seed));
			apb(1'b1, bufa(8'(i)), {$random(seed)} << 8 | b[i]);
		end
		for (int i = 0; i < 16; i++) begin
			apb(1'b0, bufa(8'(i)), 32'h0);
			chk(rd, {24'h0, b[i]});
		end
		mb = 8'($random(seed));
		sb = 8'($random(seed));
		hammer(1'b0);
		apb(1'b0, OFF_STAT, 32'h0);
		chk(rd[1:0], 2'h3);
		apb(1'b1, OFF_MASK, 32'h3);
		repeat (2) @(negedge clk);
		chk(irq, 1'b1);
		apb(1'b1, OFF_STAT, 32'h7);
		repeat (2) @(negedge clk);
		chk(irq, 1'b0);
		apb(1'b0, bufa(8'h80), 32'h0);
		chk(rd, {24'h0, mb});
		apb(1'b1, OFF_CTRL, 32'h01000107);
		apb(1'b1, OFF_BASE, 32'h40FF);
		apb(1'b1, OFF_CTRL, 32'h81000107);
		hammer(1'b1);
		apb(1'b0, OFF_CUR, 32'h0);
		chk(rd[15:0], 16'h41FF);
		apb(1'b0, bufa(8'hFF), 32'h0);
		chk(rd, {24'h0, mb});
		apb(1'b1, OFF_CTRL, 32'h0);
		apb(1'b1, OFF_CTRL, 32'h80000007);
		apb(1'b1, OFF_TXD, {24'h0, sb});
		frame();
		apb(1'b0, OFF_RXD, 32'h0);
		chk(rd[7:0], mb);
		apb(1'b1, OFF_CTRL, 32'h0);
		apb(1'b1, OFF_CTRL, 32'h80010007);
		frame();
		apb(1'b0, OFF_STAT, 32'h0);
		chk(rd[3:2], 2'h1);
		$display("slave fifo test done");
		apb(1'b1, OFF_CTRL, 32'h0);
		apb(1'b1, OFF_SPI, 32'h1);
		apb(1'b1, OFF_CTRL, 32'h80000005);
		apb(1'b1, OFF_TXD, {24'h0, mb});
		clk_gap();
		chk(n, 6);
		n = 0;
		while (ss_o !== 1'b1 && n < 400) begin
			@(negedge clk);
			n++;
		end
		apb(1'b0, OFF_RXD, 32'h0);
		chk(rd[7:0], sb);
		n = 0;
		repeat (20) begin
			@(negedge clk);
			if (sclk_o !== 1'b0) n++;
		end
		chk(n, 0);
		apb(1'b1, OFF_CTRL, 32'h0);
		apb(1'b1, OFF_SPI, 32'h21);
		apb(1'b1, OFF_CTRL, 32'h80000005);
		clk_gap();
		chk(n, 6);
		$display("master test done");
		summarize();
	end
	initial begin
		#200000;
		errors++;
		summarize();
	end
endmodule
`default_nettype wire
